// File: common/spms_pkg.sv
// Register map, field positions and reset values of the serial port.
package spms_pkg;
  // Register byte offsets on the APB bus.
  localparam logic [11:0] SPMS_OFS_CTRL = 12'h000;
  localparam logic [11:0] SPMS_OFS_STAT = 12'h004;
  localparam logic [11:0] SPMS_OFS_DATA = 12'h008;
  localparam int SPMS_ADDR_W = 12;
  // Control register fields.
  localparam int SPMS_C_RATE2 = 7;
  localparam int SPMS_C_EN = 6;
  localparam int SPMS_C_SELECT_PIN_DISABLE = 5;
  localparam int SPMS_C_MASTER_SELECT_BIT = 4;
  localparam int SPMS_C_CPOL = 3;
  localparam int SPMS_C_CPHA = 2;
  localparam int SPMS_C_RATE1 = 1;
  localparam int SPMS_C_RATE0 = 0;
  // Status register fields.
  localparam int SPMS_S_DONE = 7;
  localparam int SPMS_S_OVR = 5;
  localparam int SPMS_S_FAULT = 4;
  localparam int SPMS_S_TXE = 3;
  localparam int SPMS_S_TXIE = 2;
  // Values after reset.
  localparam logic [7:0] SPMS_CTRL_RST = 8'h00;
  localparam logic [7:0] SPMS_DATA_RST = 8'h00;
  localparam logic [6:0] SPMS_CNT_RST = 7'h00;
  // Rate codes that have no generator behind them.
  localparam logic [2:0] SPMS_RATE_NONE_LO = 3'h0;
  localparam logic [2:0] SPMS_RATE_NONE_HI = 3'h7;
  // Index of the last clock edge of a byte in master mode, and of the last sample of a byte.
  localparam logic [4:0] SPMS_LAST_EDGE = 5'h0f;
  localparam logic [2:0] SPMS_LAST_BIT = 3'h7;
  typedef enum logic {SPMS_IDLE, SPMS_XFER} spms_st_t;
endpackage : spms_pkg

// File: hw/spms_port.sv
// Serial port that works as bus master or selected slave, with an APB register file.
`timescale 1ns/10ps
//
// Contract
// - Bytes shift most significant bit first, eight bits each.
// - Master drives exactly eight clock cycles per byte, exchanging one byte each way.
// - Deselected slave releases its MISO output.
// - Master clock is peripheral clock over 4..128 for codes 1..6; 0 and 7 stop.
// - In master mode a data write starts a transfer once the shifter is free.
// - At transfer end set done flag and copy received byte in that cycle.
// - Done flag clears after status read with flag set, then data read.
// - Slave moves a full received byte to the data register and sets done.
// - Late slave write means the shifter content from before is sent.
// - Polarity bit sets the clock idle level; both ends use equal settings.
// - Phase 0 samples on the first edge; select falling starts the byte.
// - Phase 1 drives data on the first edge, which starts the byte.
// - Master with select disabled frees select and never sets mode fault.
// - Slave with phase 1 and select disabled acts as always selected.
// - Clearing select disable alone leaves a pending mode fault set.
// - Transmit empty flag stays set while buffer free, clears once loaded.
// - A queued byte starts right after the current one, with no gap.
// - Slave with no new byte sends the last byte received.
// - Master seeing select low sets fault, requests interrupt, clears enable and master.
// - On overrun the new byte is dropped, the unread one kept.
// - Slave select high clears the bit counter and ignores clock edges.
// - Transmit interrupt follows empty flag when enabled, else done flag.
module spms_port
  import spms_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // APB slave
  input wire logic [spms_pkg::SPMS_ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial pins
  input wire logic sck_i,
  output logic sck_o,
  output logic sck_oe,
  input wire logic mosi_i,
  output logic mosi_o,
  output logic mosi_oe,
  input wire logic miso_i,
  output logic miso_o,
  output logic miso_oe,
  input wire logic ss_n_i,
  // Interrupt requests
  output logic tx_irq,
  output logic fault_irq
);
  import spms_pkg::*;

  function automatic logic [6:0] half_m1(input logic [2:0] code);
    half_m1 = (7'h01 << code) - 7'h01;
  endfunction : half_m1

  logic [7:0] ctrl_q;
  logic [7:0] buf_q, rx_q, sh_q;
  logic tx_full_q, done_q, ovr_q, fault_q, txie_q, done_arm_q, fault_arm_q;
  logic out_q, sck_q, sck_oe_q, mosi_oe_q, miso_oe_q, tx_irq_q, fault_irq_q;
  logic pready_q, pslverr_q;
  logic [31:0] prdata_q;
  logic [6:0] div_q;
  logic [4:0] ecnt_q;
  logic [2:0] scnt_q;
  spms_st_t st_q;
  logic sck_s1, sck_s2, sck_s3, mosi_s1, mosi_s2, miso_s1, miso_s2, ss_s1, ss_s2, ss_s3;

  // Configuration view.
  logic en, master_select_bit, cpol, cpha, select_pin_disable;
  logic [2:0] rate;
  assign en = ctrl_q[SPMS_C_EN];
  assign master_select_bit = ctrl_q[SPMS_C_MASTER_SELECT_BIT];
  assign cpol = ctrl_q[SPMS_C_CPOL];
  assign cpha = ctrl_q[SPMS_C_CPHA];
  assign select_pin_disable = ctrl_q[SPMS_C_SELECT_PIN_DISABLE];
  assign rate = {ctrl_q[SPMS_C_RATE2], ctrl_q[SPMS_C_RATE1], ctrl_q[SPMS_C_RATE0]};

  // APB decode: one wait state, effects land at the completing edge.
  logic acc, wr_ctrl, wr_stat, wr_data, rd_stat, rd_data, mapped;
  assign acc = psel && penable && pready_q;
  assign mapped = (paddr == SPMS_OFS_CTRL) || (paddr == SPMS_OFS_STAT) ||
                  (paddr == SPMS_OFS_DATA);
  assign wr_ctrl = acc && pwrite && (paddr == SPMS_OFS_CTRL);
  assign wr_stat = acc && pwrite && (paddr == SPMS_OFS_STAT);
  assign wr_data = acc && pwrite && (paddr == SPMS_OFS_DATA);
  assign rd_stat = acc && !pwrite && (paddr == SPMS_OFS_STAT);
  assign rd_data = acc && !pwrite && (paddr == SPMS_OFS_DATA);

  logic [7:0] stat_v;
  always_comb
  begin
    stat_v = 8'h00;
    stat_v[SPMS_S_DONE] = done_q;
    stat_v[SPMS_S_OVR] = ovr_q;
    stat_v[SPMS_S_FAULT] = fault_q;
    stat_v[SPMS_S_TXE] = !tx_full_q;
    stat_v[SPMS_S_TXIE] = txie_q;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end
    else
    begin
      pready_q <= psel && penable && !pready_q;
      pslverr_q <= psel && penable && !pready_q && !mapped;
      if (psel && penable && !pready_q && !pwrite)
      begin
        case (paddr)
          SPMS_OFS_CTRL: prdata_q <= {24'h000000, ctrl_q};
          SPMS_OFS_STAT: prdata_q <= {24'h000000, stat_v};
          SPMS_OFS_DATA: prdata_q <= {24'h000000, rx_q};
          default: prdata_q <= 32'h00000000;
        endcase
      end
    end
  end

  // Pin synchronisers; the first stage feeds only the second.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      {sck_s1, sck_s2, sck_s3} <= 3'h0;
      {mosi_s1, mosi_s2, miso_s1, miso_s2} <= 4'h0;
      {ss_s1, ss_s2, ss_s3} <= 3'h7;
    end
    else
    begin
      sck_s1 <= sck_i;
      sck_s2 <= sck_s1;
      sck_s3 <= sck_s2;
      mosi_s1 <= mosi_i;
      mosi_s2 <= mosi_s1;
      miso_s1 <= miso_i;
      miso_s2 <= miso_s1;
      ss_s1 <= ss_n_i;
      ss_s2 <= ss_s1;
      ss_s3 <= ss_s2;
    end
  end

  // Edge events, shared by master and slave datapath.
  logic rate_ok, tick, sel, sl_edge, lead, trail, sample, shout, rx_in, done_ev;
  logic start_m, mfault, sfault;
  logic [7:0] rx_byte;
  assign rate_ok = (rate != SPMS_RATE_NONE_LO) && (rate != SPMS_RATE_NONE_HI);
  assign tick = en && master_select_bit && (st_q == SPMS_XFER) && (div_q == half_m1(rate));
  assign sel = en && !master_select_bit && ((select_pin_disable && cpha) || !ss_s2);
  assign sl_edge = sel && (sck_s2 != sck_s3);
  // In master mode even edge indexes are leading edges.
  assign lead = master_select_bit ? (tick && !ecnt_q[0]) : (sl_edge && (sck_s3 == cpol));
  assign trail = master_select_bit ? (tick && ecnt_q[0]) : (sl_edge && (sck_s3 != cpol));
  assign sample = cpha ? trail : lead;
  assign shout = cpha ? lead : trail;
  assign rx_in = master_select_bit ? miso_s2 : mosi_s2;
  assign rx_byte = sample ? {sh_q[6:0], rx_in} : sh_q;
  assign done_ev = master_select_bit ? (tick && (ecnt_q == SPMS_LAST_EDGE)) :
                   (sample && (st_q == SPMS_XFER || !cpha || lead) && (scnt_q == SPMS_LAST_BIT));
  assign start_m = en && master_select_bit && rate_ok && tx_full_q && (st_q == SPMS_IDLE);
  assign mfault = en && master_select_bit && !select_pin_disable && !ss_s2;
  assign sfault = en && !master_select_bit && !(select_pin_disable && cpha) && (st_q == SPMS_XFER) && ss_s2 && !ss_s3;

  // Control register; a mode fault drops enable and master.
  always_ff @(posedge clk)
  begin
    if (srst)
      ctrl_q <= SPMS_CTRL_RST;
    else if (mfault)
    begin
      ctrl_q[SPMS_C_EN] <= 1'b0;
      ctrl_q[SPMS_C_MASTER_SELECT_BIT] <= 1'b0;
    end
    else if (wr_ctrl)
      ctrl_q <= pwdata[7:0];
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      txie_q <= 1'b0;
    else if (wr_stat)
      txie_q <= pwdata[SPMS_S_TXIE];
  end

  // Transmit buffer: one byte; writes while full are ignored.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      buf_q <= SPMS_DATA_RST;
      tx_full_q <= 1'b0;
    end
    else
    begin
      if (wr_data && !tx_full_q)
      begin
        buf_q <= pwdata[7:0];
        tx_full_q <= 1'b1;
      end
      // A deselected slave keeps its byte queued, because its shifter only loads once selected.
      else if (start_m || (master_select_bit && done_ev && tx_full_q) ||
               (sel && st_q == SPMS_IDLE && tx_full_q && !lead))
        tx_full_q <= 1'b0;
    end
  end

  // Shift engine.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      st_q <= SPMS_IDLE;
      sh_q <= SPMS_DATA_RST;
      out_q <= 1'b0;
      div_q <= SPMS_CNT_RST;
      ecnt_q <= 5'h00;
      scnt_q <= 3'h0;
    end
    else if (!en || mfault || (!master_select_bit && !sel))
    begin
      // Disable acts as an internal reset; deselect drops a half byte.
      st_q <= SPMS_IDLE;
      div_q <= SPMS_CNT_RST;
      ecnt_q <= 5'h00;
      scnt_q <= 3'h0;
    end
    else if (master_select_bit)
    begin
      if (start_m)
      begin
        st_q <= SPMS_XFER;
        sh_q <= buf_q;
        out_q <= buf_q[7];
        div_q <= SPMS_CNT_RST;
        ecnt_q <= 5'h00;
        scnt_q <= 3'h0;
      end
      else if (st_q == SPMS_XFER)
      begin
        div_q <= tick ? SPMS_CNT_RST : div_q + 7'h01;
        if (tick)
          ecnt_q <= ecnt_q + 5'h01;
        if (sample)
        begin
          sh_q <= rx_byte;
          scnt_q <= scnt_q + 3'h1;
        end
        if (shout)
          out_q <= sample ? rx_byte[7] : sh_q[7];
        if (done_ev)
        begin
          // The queued byte follows at the same clock cadence.
          if (tx_full_q)
          begin
            sh_q <= buf_q;
            out_q <= buf_q[7];
            ecnt_q <= 5'h00;
          end
          else
            st_q <= SPMS_IDLE;
        end
      end
    end
    else
    begin
      if (st_q == SPMS_IDLE && tx_full_q && !lead)
      begin
        sh_q <= buf_q;
        out_q <= buf_q[7];
      end
      else
      begin
        if (st_q == SPMS_IDLE && !cpha)
          out_q <= sh_q[7];
        if (lead)
          st_q <= SPMS_XFER;
        if (sample)
        begin
          sh_q <= rx_byte;
          scnt_q <= scnt_q + 3'h1;
        end
        if (shout && !(done_ev && !cpha))
          out_q <= sample ? rx_byte[7] : sh_q[7];
        if (done_ev)
          st_q <= SPMS_IDLE;
      end
    end
  end

  // Done, overrun and receive register; a new event wins over a clear.
  logic done_clr;
  assign done_clr = done_arm_q && rd_data;
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      rx_q <= SPMS_DATA_RST;
      done_q <= 1'b0;
      ovr_q <= 1'b0;
      done_arm_q <= 1'b0;
    end
    else
    begin
      if (rd_stat)
        done_arm_q <= done_q;
      else if (done_clr)
        done_arm_q <= 1'b0;
      if (done_ev && done_q && !done_clr)
        ovr_q <= 1'b1;
      else if (done_clr)
        ovr_q <= 1'b0;
      if (done_ev && !(done_q && !done_clr))
      begin
        rx_q <= rx_byte;
        done_q <= 1'b1;
      end
      else if (done_clr)
        done_q <= 1'b0;
    end
  end

  // Mode fault clears by a status read with it set, then a control write.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      fault_q <= 1'b0;
      fault_arm_q <= 1'b0;
    end
    else
    begin
      if (rd_stat)
        fault_arm_q <= fault_q;
      else if (wr_ctrl)
        fault_arm_q <= 1'b0;
      if (mfault || sfault)
        fault_q <= 1'b1;
      else if (fault_arm_q && wr_ctrl)
        fault_q <= 1'b0;
    end
  end

  // Pin drivers and interrupt requests, all registered.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      sck_q <= 1'b0;
      sck_oe_q <= 1'b0;
      mosi_oe_q <= 1'b0;
      miso_oe_q <= 1'b0;
      tx_irq_q <= 1'b0;
      fault_irq_q <= 1'b0;
    end
    else
    begin
      sck_q <= (en && master_select_bit && st_q == SPMS_XFER && !start_m) ? (sck_q ^ tick) : cpol;
      sck_oe_q <= en && master_select_bit && !mfault;
      mosi_oe_q <= en && master_select_bit && !mfault;
      miso_oe_q <= sel;
      tx_irq_q <= txie_q ? !tx_full_q : done_q;
      fault_irq_q <= fault_q || mfault;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign sck_o = sck_q;
  assign sck_oe = sck_oe_q;
  assign mosi_o = out_q;
  assign mosi_oe = mosi_oe_q;
  assign miso_o = out_q;
  assign miso_oe = miso_oe_q;
  assign tx_irq = tx_irq_q;
  assign fault_irq = fault_irq_q;

  // Helper: cycles between master clock toggles.
  logic [7:0] gap_q;
  always_ff @(posedge clk)
  begin
    if (srst || !(en && master_select_bit && st_q == SPMS_XFER) || sck_q != $past(sck_q))
      gap_q <= 8'h01;
    else
      gap_q <= gap_q + 8'h01;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence s_ms_fault;
    en && master_select_bit && !select_pin_disable && !ss_s2;
  endsequence
  sequence s_tripped;
    fault_q && !ctrl_q[SPMS_C_EN] && !ctrl_q[SPMS_C_MASTER_SELECT_BIT];
  endsequence

  done_set_a: assert property (done_ev |=> done_q)
    else $error("done flag not set at end of transfer");
  rx_copy_a: assert property (done_ev && !done_q |=> rx_q == $past(rx_byte))
    else $error("received byte not copied");
  overrun_keep_a: assert property (done_ev && done_q && !done_clr |=> $stable(rx_q) && ovr_q)
    else $error("overrun overwrote unread byte");
  done_hold_a: assert property (done_q && !done_arm_q |=> done_q)
    else $error("done cleared without status read");
  done_clear_a: assert property (done_arm_q && rd_data && !done_ev |=> !done_q)
    else $error("done not cleared by read sequence");
  fault_trip_a: assert property (s_ms_fault |=> s_tripped ##1 fault_irq)
    else $error("mode fault did not trip");
  select_pin_disable_nofault_a: assert property (en && master_select_bit && select_pin_disable && !fault_q |=> !fault_q)
    else $error("mode fault set with select disabled");
  deselect_a: assert property (en && !master_select_bit && ss_s2 && !(select_pin_disable && cpha)
                               |=> !miso_oe && scnt_q == 3'h0 ##1 miso_oe == $past(sel))
    else $error("deselected slave still drives or counts");
  queue_a: assert property (master_select_bit && done_ev && tx_full_q |=> st_q == SPMS_XFER && !tx_full_q)
    else $error("queued byte did not follow at once");
  tx_load_a: assert property (wr_data && !tx_full_q |=> tx_full_q)
    else $error("transmit empty did not clear on write");
  rate_gap_a: assert property (en && master_select_bit && st_q == SPMS_XFER && sck_q != $past(sck_q) &&
                               $past(st_q) == SPMS_XFER && $past(sck_q, 2) == $past(sck_q)
                               |-> gap_q >= {1'b0, half_m1(rate)})
    else $error("master clock half period too short");
endmodule : spms_port

// File: sim/spms_far_slave.sv
// Behavioural far-end slave that answers the port while it runs as master.
`timescale 1ns/10ps
module spms_far_slave (
  // Control
  input wire logic srst,
  input wire logic cpol,
  input wire logic [7:0] tx_byte,
  // Serial lines
  input wire logic sck,
  input wire logic mosi,
  output logic miso,
  // Observation
  output logic [7:0] rx_byte,
  output int edges,
  output int nbytes
);
  logic [7:0] tx_sh;
  logic [7:0] rx_sh;
  int cnt;
  // The first bit is on the line before the first clock edge.
  assign miso = tx_sh[7];
  always @(sck or srst)
  begin
    if (srst)
    begin
      tx_sh = tx_byte;
      cnt = 0;
      edges = 0;
      nbytes = 0;
    end
    else if (sck !== cpol)
    begin
      rx_sh = {rx_sh[6:0], mosi};
      cnt++;
      edges++;
    end
    else if (cnt == 8)
    begin
      // Reload only after the eighth sample, so a byte is never split.
      rx_byte = rx_sh;
      nbytes++;
      cnt = 0;
      tx_sh = tx_byte;
    end
    else if (cnt != 0)
      tx_sh = {tx_sh[6:0], 1'b1};
  end
endmodule : spms_far_slave

// File: sim/spi_master_slave_port_bench.sv
// Self-checking bench for the serial port in master and slave roles.
`timescale 1ns/10ps
module spi_master_slave_port_bench;
  import spms_pkg::*;
  logic clk, srst, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic sck_i, sck_o, sck_oe, mosi_i, mosi_o, mosi_oe, miso_o, miso_oe, ss_n_i;
  logic tx_irq, fault_irq, far_miso;
  logic [7:0] far_tx, far_rx, got;
  int far_edges, far_bytes, num_errors, total_checks;
  int cycles = 0;
  spms_port dut_u (.clk(clk), .srst(srst), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sck_i(sck_i), .sck_o(sck_o), .sck_oe(sck_oe), .mosi_i(mosi_i), .mosi_o(mosi_o),
    .mosi_oe(mosi_oe), .miso_i(far_miso), .miso_o(miso_o), .miso_oe(miso_oe),
    .ss_n_i(ss_n_i), .tx_irq(tx_irq), .fault_irq(fault_irq));
  // Released lines settle to the idle clock level and a pulled-up data level.
  spms_far_slave far_u (.srst(srst), .cpol(1'b0), .tx_byte(far_tx),
    .sck(sck_oe ? sck_o : 1'b0), .mosi(mosi_oe ? mosi_o : 1'b1), .miso(far_miso),
    .rx_byte(far_rx), .edges(far_edges), .nbytes(far_bytes));
  function automatic logic [31:0] z1(input logic x);
    return {31'h0, x};
  endfunction : z1
  task automatic print_verdict;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : print_verdict
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    total_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // One APB transfer; the answer is awaited, never assumed.
  task automatic apb(input logic [11:0] a, input logic w, input logic [7:0] wd);
    int n;
    n = 0;
    paddr <= a;
    pwrite <= w;
    pwdata <= {24'h000000, wd};
    psel <= 1'b1;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 20)
    begin
      @(posedge clk);
      n++;
    end
    chk("pready", 32'h1, z1(pready));
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  // External master; half periods of six clocks keep the link under a quarter of clk.
  task automatic slave_byte(input logic ph, input logic [7:0] m, output logic [7:0] s);
    ss_n_i <= ph;
    repeat (6) @(posedge clk);
    for (int i = 7; i >= 0; i--)
    begin
      mosi_i <= m[i];
      if (ph)
        sck_i <= 1'b1;
      repeat (6) @(posedge clk);
      s[i] = miso_o;
      sck_i <= !ph;
      repeat (6) @(posedge clk);
      if (!ph)
        sck_i <= 1'b0;
    end
    repeat (6) @(posedge clk);
    ss_n_i <= 1'b1;
    repeat (6) @(posedge clk);
  endtask : slave_byte
  task automatic t_reset;
    chk("miso oe at reset", 32'h0, z1(miso_oe));
    apb(SPMS_OFS_CTRL, 1'b0, 8'h00);
    chk("ctrl reset", 32'h00, rd);
    apb(SPMS_OFS_STAT, 1'b0, 8'h00);
    chk("status reset", 32'h08, rd);
    apb(12'h00c, 1'b0, 8'h00);
    chk("unmapped err", 32'h1, z1(err));
    chk("unmapped data", 32'h0, rd);
    $display("end reset test");
  endtask : t_reset
  task automatic t_master;
    int e0, n;
    e0 = far_edges;
    n = 0;
    apb(SPMS_OFS_CTRL, 1'b1, 8'h53);
    apb(SPMS_OFS_DATA, 1'b1, 8'ha5);
    while (tx_irq !== 1'b1 && n < 400)
    begin
      @(posedge clk);
      n++;
    end
    chk("done irq", 32'h1, z1(tx_irq));
    chk("far rx", 32'ha5, {24'h0, far_rx});
    chk("sck cycles", 32'd8, far_edges - e0);
    apb(SPMS_OFS_DATA, 1'b0, 8'h00);
    chk("rx data", 32'h3c, rd);
    apb(SPMS_OFS_STAT, 1'b0, 8'h00);
    chk("done kept", 32'h1, z1(rd[SPMS_S_DONE]));
    apb(SPMS_OFS_DATA, 1'b0, 8'h00);
    apb(SPMS_OFS_STAT, 1'b0, 8'h00);
    chk("done cleared", 32'h0, z1(rd[SPMS_S_DONE]));
    $display("end master test");
  endtask : t_master
  task automatic t_queue;
    int b0, n;
    b0 = far_bytes;
    n = 0;
    apb(SPMS_OFS_DATA, 1'b1, 8'h81);
    apb(SPMS_OFS_DATA, 1'b1, 8'h7e);
    far_tx <= 8'h99;
    apb(SPMS_OFS_STAT, 1'b0, 8'h00);
    chk("tx empty low", 32'h0, z1(rd[SPMS_S_TXE]));
    // Two bytes at divisor 16 take 256 cycles; the bound of 290 would also pass a gap of two clock periods.
    while (far_bytes < b0 + 2 && n < 290)
    begin
      @(posedge clk);
      n++;
    end
    repeat (8) @(posedge clk);
    chk("queued byte", 32'h7e, {24'h0, far_rx});
    apb(SPMS_OFS_STAT, 1'b0, 8'h00);
    chk("overrun", 32'h1, z1(rd[SPMS_S_OVR]));
    chk("tx empty again", 32'h1, z1(rd[SPMS_S_TXE]));
    apb(SPMS_OFS_DATA, 1'b0, 8'h00);
    chk("unread kept", 32'h3c, rd);
    $display("end queue test");
  endtask : t_queue
  task automatic t_fault;
    ss_n_i <= 1'b0;
    repeat (6) @(posedge clk);
    chk("fault irq", 32'h1, z1(fault_irq));
    apb(SPMS_OFS_CTRL, 1'b0, 8'h00);
    chk("ctrl after fault", 32'h03, rd);
    apb(SPMS_OFS_STAT, 1'b0, 8'h00);
    chk("fault flag", 32'h1, z1(rd[SPMS_S_FAULT]));
    apb(SPMS_OFS_CTRL, 1'b1, 8'h73);
    repeat (6) @(posedge clk);
    apb(SPMS_OFS_STAT, 1'b0, 8'h00);
    chk("no fault", 32'h0, z1(rd[SPMS_S_FAULT]));
    chk("no fault irq", 32'h0, z1(fault_irq));
    ss_n_i <= 1'b1;
    apb(SPMS_OFS_CTRL, 1'b1, 8'h00);
    $display("end fault test");
  endtask : t_fault
  task automatic t_slave;
    apb(SPMS_OFS_CTRL, 1'b1, 8'h40);
    chk("miso released", 32'h0, z1(miso_oe));
    apb(SPMS_OFS_DATA, 1'b1, 8'hc3);
    slave_byte(1'b0, 8'h5a, got);
    chk("slave sent", 32'hc3, {24'h0, got});
    chk("miso off", 32'h0, z1(miso_oe));
    apb(SPMS_OFS_STAT, 1'b0, 8'h00);
    chk("slave done", 32'h1, z1(rd[SPMS_S_DONE]));
    apb(SPMS_OFS_DATA, 1'b0, 8'h00);
    chk("slave rx", 32'h5a, rd);
    slave_byte(1'b0, 8'h11, got);
    chk("echo last rx", 32'h5a, {24'h0, got});
    apb(SPMS_OFS_STAT, 1'b0, 8'h00);
    apb(SPMS_OFS_DATA, 1'b0, 8'h00);
    chk("second rx", 32'h11, rd);
    $display("end slave test");
  endtask : t_slave
  task automatic t_phase1;
    apb(SPMS_OFS_CTRL, 1'b1, 8'h00);
    apb(SPMS_OFS_CTRL, 1'b1, 8'h24);
    apb(SPMS_OFS_CTRL, 1'b1, 8'h64);
    apb(SPMS_OFS_DATA, 1'b1, 8'h96);
    slave_byte(1'b1, 8'h2d, got);
    chk("phase 1 sent", 32'h96, {24'h0, got});
    apb(SPMS_OFS_STAT, 1'b0, 8'h00);
    chk("phase 1 done", 32'h1, z1(rd[SPMS_S_DONE]));
    apb(SPMS_OFS_DATA, 1'b0, 8'h00);
    chk("phase 1 rx", 32'h2d, rd);
    apb(SPMS_OFS_CTRL, 1'b1, 8'h00);
    $display("end phase 1 test");
  endtask : t_phase1
  task automatic t_norate;
    int e0;
    apb(SPMS_OFS_STAT, 1'b1, 8'h04);
    apb(SPMS_OFS_CTRL, 1'b1, 8'h58);
    // Enabling with a high idle level makes one edge at the far end; count after it.
    @(posedge clk);
    e0 = far_edges;
    chk("tx empty irq", 32'h1, z1(tx_irq));
    chk("sck idle high", 32'h1, z1(sck_o));
    apb(SPMS_OFS_DATA, 1'b1, 8'h66);
    repeat (300) @(posedge clk);
    chk("no clock", 32'd0, far_edges - e0);
    chk("tx full irq", 32'h0, z1(tx_irq));
    apb(SPMS_OFS_STAT, 1'b0, 8'h00);
    chk("no done", 32'h0, z1(rd[SPMS_S_DONE]));
    $display("end rate test");
  endtask : t_norate
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 6000)
    begin
      num_errors++;
      print_verdict;
    end
  end
  initial
  begin
    srst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    sck_i = 1'b0;
    mosi_i = 1'b0;
    ss_n_i = 1'b1;
    far_tx = 8'h3c;
    num_errors = 0;
    total_checks = 0;
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    t_reset;
    t_master;
    t_queue;
    t_fault;
    t_slave;
    t_phase1;
    t_norate;
    print_verdict;
  end
endmodule : spi_master_slave_port_bench
